/* rtl/eic_ctrl.sv */
`timescale 1ns/1ps
`include "eic_params.svh"
// Contract
// - Interleave burst beats across two DRAM ways
// - 72-bit ECC, correct single-bit read errors
// - Support 16, 32, 64, 128 MB totals
// - Two blocks of nine devices, A and B
// - Aligned burst read from idle: 9,1,2,1
// - Misaligned burst read from idle: 9,3,1,1
// - Aligned read after read: 7/3, then 1,2,1
// - Misaligned read after read: 6/2, then 3,1,1
// - Burst write from idle: 4,1,1,1
// - Write after write: 7/3, then 1,1,1
// - Single read from idle: 9 clocks
// - Single read after single read: 8/6
// - Single write from idle: 4 clocks
// - Single write after single write: 12/10
// - PCI reads 10 clocks, writes 3, then one/beat
// - PCI figures include two arbitration clocks
// - PCI write figures assume empty posting FIFO
// - Some figures are averages
module eic_ctrl
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        transfer_start_n,
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_write,
  input  wire logic        bus_burst,
  input  wire logic [63:0] bus_wr_data,
  input  wire logic        bus_hold,
  output logic             address_ack_n,
  output logic             transfer_ack_n,
  output logic      [63:0] bus_rd_data,
  input  wire logic        mem_two_blocks,
  input  wire logic [1:0]  mem_size_sel,
  output logic      [1:0]  ras_n,
  output logic      [1:0]  cas_n,
  output logic      [11:0] dram_addr,
  output logic             dram_we_n,
  input  wire logic [71:0] dram_dq_in,
  output logic      [71:0] dram_dq_out,
  output logic             dram_dq_oe,
  output logic             ecc_single_fix,
  output logic             ecc_multi_err,
  input  wire logic        pci_req,
  input  wire logic        pci_write,
  input  wire logic        pci_burst,
  input  wire logic        pci_last,
  input  wire logic [31:0] pci_addr,
  input  wire logic [63:0] pci_wr_data,
  input  wire logic        pci_post_empty,
  output logic             pci_beat,
  output logic      [63:0] pci_rd_data
);

  eic_pkg::eic_regs_t r;
  eic_pkg::eic_regs_t next_r;
  eic_pkg::eic_kind_t kind_in;

  logic [14:0] row_in;
  logic        blk_in;
  logic        mis_in;
  logic        same;
  logic        hit;
  logic [3:0]  first_wait;
  logic [3:0]  pci_first;
  logic [1:0]  last_beat;
  logic [1:0]  nb;
  logic [3:0]  gap;
  logic [1:0]  beat_addr;
  logic [1:0]  ahead_addr;
  logic        ahead_rd;
  logic        is_read;
  logic        stall;
  logic        cpu_evt;
  logic        rd_event;
  logic [1:0]  cnt_v;
  logic        pop;
  logic [63:0] enc_src;
  logic [71:0] enc_code;
  logic [63:0] dec_data;
  logic        dec_single;
  logic        dec_multi;

  // ===================================================================
  // Request decode
  // ===================================================================
  always_comb
  begin
    if (bus_write)
      kind_in = bus_burst ? eic_pkg::EIC_K_BWR : eic_pkg::EIC_K_SWR;
    else
      kind_in = bus_burst ? eic_pkg::EIC_K_BRD : eic_pkg::EIC_K_SRD;
    mis_in = bus_addr[4:3] != 2'h0;
    row_in = bus_addr[`EIC_ROW_MSB:`EIC_ROW_LSB];
    // Block select bit moves with the populated size
    blk_in = mem_two_blocks &
             bus_addr[`EIC_BLK_BIT_BASE + {3'h0, mem_size_sel}];
    // Back-to-back only when the start lands in the slot after the last
    // beat; a later start counts as from idle
    same = r.b2b && (r.prev_kind == kind_in);
    hit = r.b2b && r.open_valid && (r.open_row == row_in) &&
          (r.open_blk == blk_in);
    case (kind_in)
      eic_pkg::EIC_K_BRD:
      begin
        if (!same)
          first_wait = `EIC_RD_IDLE;
        else if (mis_in)
          first_wait = hit ? `EIC_RD_MA_HIT : `EIC_RD_MA_MISS;
        else
          first_wait = hit ? `EIC_RD_AL_HIT : `EIC_RD_AL_MISS;
      end
      eic_pkg::EIC_K_BWR:
      begin
        if (!same)
          first_wait = `EIC_WR_IDLE;
        else
          first_wait = hit ? `EIC_WR_HIT : `EIC_WR_MISS;
      end
      eic_pkg::EIC_K_SRD:
      begin
        if (!same)
          first_wait = `EIC_SR_IDLE;
        else
          first_wait = hit ? `EIC_SR_HIT : `EIC_SR_MISS;
      end
      default:
      begin
        if (!same)
          first_wait = `EIC_SW_IDLE;
        else
          first_wait = hit ? `EIC_SW_HIT : `EIC_SW_MISS;
      end
    endcase
  end

  // ===================================================================
  // Beat pacing
  // ===================================================================
  always_comb
  begin
    is_read = (r.kind == eic_pkg::EIC_K_BRD) ||
              (r.kind == eic_pkg::EIC_K_SRD);
    last_beat = ((r.kind == eic_pkg::EIC_K_BRD) ||
                 (r.kind == eic_pkg::EIC_K_BWR)) ? 2'h3 : 2'h0;
    nb = r.beat + 2'h1;
    if (!is_read)
      gap = `EIC_WR_GAP;
    else if (r.mis)
      gap = (nb == 2'h1) ? `EIC_RD_MA_GAP2 :
            (nb == 2'h2) ? `EIC_RD_MA_GAP3 : `EIC_RD_MA_GAP4;
    else
      gap = (nb == 2'h1) ? `EIC_RD_AL_GAP2 :
            (nb == 2'h2) ? `EIC_RD_AL_GAP3 : `EIC_RD_AL_GAP4;
    // Critical beat first, then wrap within the quad word
    beat_addr = r.addr[4:3] + r.beat;
    // Full buffer stalls the DRAM side rather than dropping a word
    stall = is_read && (r.bcnt == 2'h2);
    cpu_evt = (r.st == eic_pkg::EIC_CPU) && (r.cnt == 4'h1) && !stall;
    // figures include arbitration, taken off here; a non-empty posting FIFO stretches writes
    pci_first = (r.pci_wr ? `EIC_PCI_WR_FIRST : `EIC_PCI_RD_FIRST) -
                `EIC_ARB_PCI;
    if (r.pci_wr && !pci_post_empty)
      pci_first = pci_first + `EIC_POST_EXTRA;
    enc_src = (r.st == eic_pkg::EIC_PCI) ? pci_wr_data : bus_wr_data;
  end

  eic_ecc u_ecc
  (
    .wr_data   (enc_src),
    .wr_code   (enc_code),
    .rd_code   (dram_dq_in),
    .rd_data   (dec_data),
    .rd_single (dec_single),
    .rd_multi  (dec_multi)
  );

  // ===================================================================
  // Main sequencer
  // ===================================================================
  always_comb
  begin
    next_r = r;
    rd_event = 1'b0;
    next_r.address_ack_n_n = 1'b1;
    next_r.ta_n = 1'b1;
    next_r.cas_n = 2'h3;
    next_r.we_n = 1'b1;
    next_r.dq_oe = 1'b0;
    next_r.fix = 1'b0;
    next_r.merr = 1'b0;
    next_r.pci_beat = 1'b0;
    // Free-running PCI clock enable
    if (r.div == `EIC_PCI_DIV - 2'h1)
    begin
      next_r.div = 2'h0;
      next_r.pci_en = 1'b1;
    end
    else
    begin
      next_r.div = r.div + 2'h1;
      next_r.pci_en = 1'b0;
    end
    case (r.st)
      eic_pkg::EIC_IDLE:
      begin
        next_r.b2b = 1'b0;
        if (!transfer_start_n)
        begin
          next_r.st = eic_pkg::EIC_CPU;
          next_r.addr = bus_addr;
          next_r.kind = kind_in;
          next_r.mis = mis_in;
          next_r.beat = 2'h0;
          next_r.address_ack_n_n = 1'b0;
          next_r.cnt = first_wait - 4'h1;
          next_r.open_valid = 1'b1;
          next_r.open_row = row_in;
          next_r.open_blk = blk_in;
          next_r.ras_n = blk_in ? 2'h1 : 2'h2;
          next_r.dram_addr = row_in[11:0];
        end
        else
        begin
          // Page closes once the pipelined slot passes
          next_r.open_valid = 1'b0;
          next_r.ras_n = 2'h3;
          if (pci_req)
          begin
            next_r.st = eic_pkg::EIC_ARB;
            next_r.arb = `EIC_ARB_CLKS - 2'h1;
            next_r.pci_wr = pci_write;
            next_r.pci_burst = pci_burst;
            next_r.addr = pci_addr;
          end
        end
      end
      eic_pkg::EIC_CPU:
      begin
        if (cpu_evt)
        begin
          next_r.last_way = beat_addr[0];
          if (is_read)
          begin
            rd_event = 1'b1;
            next_r.fix = dec_single;
            next_r.merr = dec_multi;
          end
          else
          begin
            next_r.cas_n = beat_addr[0] ? 2'h1 : 2'h2;
            next_r.dram_addr = {3'h0, r.addr[`EIC_COL_MSB:`EIC_COL_LSB],
                                beat_addr};
            next_r.ta_n = 1'b0;
            next_r.we_n = 1'b0;
            next_r.dq_out = enc_code;
            next_r.dq_oe = 1'b1;
          end
          if (r.beat == last_beat)
          begin
            next_r.st = eic_pkg::EIC_IDLE;
            next_r.b2b = 1'b1;
            next_r.prev_kind = r.kind;
          end
          else
          begin
            next_r.beat = nb;
            next_r.cnt = gap;
          end
        end
        else if (!stall)
          next_r.cnt = r.cnt - 4'h1;
      end
      eic_pkg::EIC_ARB:
      begin
        if (r.arb == 2'h0)
        begin
          next_r.st = eic_pkg::EIC_PCI;
          next_r.cnt = pci_first;
          next_r.ras_n = (mem_two_blocks &
            r.addr[`EIC_BLK_BIT_BASE + {3'h0, mem_size_sel}]) ?
            2'h1 : 2'h2;
          next_r.dram_addr = r.addr[23:12];
        end
        else
          next_r.arb = r.arb - 2'h1;
      end
      eic_pkg::EIC_PCI:
      begin
        if (r.pci_en)
        begin
          if (r.cnt == 4'h1)
          begin
            next_r.pci_beat = 1'b1;
            if (r.pci_wr)
            begin
              next_r.cas_n = r.addr[3] ? 2'h1 : 2'h2;
              next_r.dram_addr = {3'h0, r.addr[`EIC_COL_MSB:3]};
              next_r.we_n = 1'b0;
              next_r.dq_out = enc_code;
              next_r.dq_oe = 1'b1;
            end
            else
            begin
              next_r.pci_rd_data = dec_data;
              next_r.fix = dec_single;
              next_r.merr = dec_multi;
            end
            if (r.pci_burst && !pci_last)
              next_r.addr = r.addr + 32'h8;
            else
              next_r.st = eic_pkg::EIC_IDLE;
          end
          else
            next_r.cnt = r.cnt - 4'h1;
        end
      end
      default:
      begin
        next_r = eic_pkg::EIC_RST;
      end
    endcase
    // Reads put the column out a cycle ahead, so the code word already
    // stands on the data pins in the cycle that samples it
    ahead_rd = (next_r.st == eic_pkg::EIC_CPU) ?
               ((next_r.kind == eic_pkg::EIC_K_BRD) ||
                (next_r.kind == eic_pkg::EIC_K_SRD)) :
               ((next_r.st == eic_pkg::EIC_PCI) && !next_r.pci_wr);
    ahead_addr = (next_r.st == eic_pkg::EIC_PCI) ? next_r.addr[4:3] :
                 next_r.addr[4:3] + next_r.beat;
    if (ahead_rd && (next_r.cnt == 4'h1))
    begin
      next_r.cas_n = ahead_addr[0] ? 2'h1 : 2'h2;
      next_r.dram_addr = {3'h0, next_r.addr[`EIC_COL_MSB:`EIC_COL_LSB],
                          ahead_addr};
    end
    // =================================================================
    // Two-entry read buffer toward the bus
    // =================================================================
    pop = !bus_hold && (r.bcnt != 2'h0);
    cnt_v = r.bcnt;
    if (pop)
    begin
      next_r.rd_data = r.s0;
      next_r.ta_n = 1'b0;
      next_r.s0 = r.s1;
      cnt_v = cnt_v - 2'h1;
    end
    if (rd_event)
    begin
      if (!pop && (r.bcnt == 2'h0) && !bus_hold)
      begin
        next_r.rd_data = dec_data;
        next_r.ta_n = 1'b0;
      end
      else
      begin
        if (cnt_v == 2'h0)
          next_r.s0 = dec_data;
        else
          next_r.s1 = dec_data;
        cnt_v = cnt_v + 2'h1;
      end
    end
    next_r.bcnt = cnt_v;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      r <= eic_pkg::EIC_RST;
    else
      r <= next_r;
  end

  assign address_ack_n  = r.address_ack_n_n;
  assign transfer_ack_n = r.ta_n;
  assign bus_rd_data    = r.rd_data;
  assign ras_n          = r.ras_n;
  assign cas_n          = r.cas_n;
  assign dram_addr      = r.dram_addr;
  assign dram_we_n      = r.we_n;
  assign dram_dq_out    = r.dq_out;
  assign dram_dq_oe     = r.dq_oe;
  assign ecc_single_fix = r.fix;
  assign ecc_multi_err  = r.merr;
  assign pci_beat       = r.pci_beat;
  assign pci_rd_data    = r.pci_rd_data;

  // ===================================================================
  // Checks
  // ===================================================================
  way_alternate_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cpu_evt && (r.beat != 2'h0)) |-> (beat_addr[0] != r.last_way))
    else $error("burst beat did not change way");

  ecc_fix_flag_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cpu_evt && is_read && dec_single) |=> (ecc_single_fix && !ecc_multi_err))
    else $error("single-bit fix not flagged");

  rd_al_idle_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (r.st == eic_pkg::EIC_IDLE && !r.b2b && !transfer_start_n &&
     !bus_write && bus_burst && bus_addr[4:3] == 2'h0)
    ##1 !bus_hold [*8] ##1 !bus_hold [*4]
    |-> ##1 !transfer_ack_n)
    else $error("aligned burst read did not end at clock 13");

  rd_mis_idle_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (r.st == eic_pkg::EIC_IDLE && !r.b2b && !transfer_start_n &&
     !bus_write && bus_burst && bus_addr[4:3] != 2'h0)
    ##1 !bus_hold [*8] ##1 !bus_hold [*3]
    |-> transfer_ack_n ##1 !transfer_ack_n)
    else $error("misaligned second beat not at clock 12");

  wr_burst_idle_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (r.st == eic_pkg::EIC_IDLE && !r.b2b && !transfer_start_n &&
     bus_write && bus_burst)
    |-> ##3 transfer_ack_n ##1 !transfer_ack_n [*4])
    else $error("burst write beats not at 4,5,6,7");

  sr_idle_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (r.st == eic_pkg::EIC_IDLE && !r.b2b && !transfer_start_n &&
     !bus_write && !bus_burst) ##8 !bus_hold
    |-> ##1 !transfer_ack_n)
    else $error("single read not done at clock 9");

  sw_idle_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (r.st == eic_pkg::EIC_IDLE && !r.b2b && !transfer_start_n &&
     bus_write && !bus_burst) |-> ##4 !transfer_ack_n)
    else $error("single write not acked at clock 4");

  arb_two_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(r.st == eic_pkg::EIC_ARB) |->
    (r.st == eic_pkg::EIC_ARB) [*2] ##1 (r.st == eic_pkg::EIC_PCI))
    else $error("arbitration not two clocks");

  multi_flag_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cpu_evt && is_read && dec_multi) |=> ecc_multi_err)
    else $error("multi-bit error not flagged");

  page_close_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (r.st == eic_pkg::EIC_IDLE && transfer_start_n)
    |=> (!r.open_valid && ras_n == 2'h3))
    else $error("page left open while idle");

endmodule // eic_ctrl

/* rtl/eic_ecc.sv */
`timescale 1ns/1ps
// Code word: bit 0 overall parity, bits 1..71 Hamming positions,
// check bits at the power-of-two positions.
module eic_ecc
(
  input  wire logic [63:0] wr_data,
  output logic      [71:0] wr_code,
  input  wire logic [71:0] rd_code,
  output logic      [63:0] rd_data,
  output logic             rd_single,
  output logic             rd_multi
);

  logic [71:0] placed;
  logic [71:0] fixed;
  logic [6:0]  wsyn;
  logic [6:0]  rsyn;

  // Syndrome is the xor of the positions of all set bits
  function automatic logic [6:0] eic_syn(input logic [71:0] c);
    logic [6:0] s;
    s = 7'h00;
    for (int p = 1; p < 72; p++)
    begin
      if (c[p])
        s = s ^ 7'(p);
    end
    return s;
  endfunction

  genvar p;
  generate
    for (p = 1; p < 72; p++)
    begin : g_pos
      if ((p & (p - 1)) != 0)
      begin : g_data
        assign placed[p] = wr_data[p - 1 - $clog2(p + 1)];
        assign rd_data[p - 1 - $clog2(p + 1)] = fixed[p];
      end
      else
      begin : g_chk
        assign placed[p] = 1'b0;
      end
    end
  endgenerate

  assign placed[0] = 1'b0;

  always_comb
  begin
    wsyn = eic_syn(placed);
    wr_code = placed;
    for (int i = 0; i < 7; i++)
      wr_code[1 << i] = wsyn[i];
    wr_code[0] = ^wr_code[71:1];
  end

  // Odd parity means one flip; even parity with a syndrome means two
  always_comb
  begin
    rsyn = eic_syn(rd_code);
    rd_single = ^rd_code;
    rd_multi = (rsyn != 7'h00) && !rd_single;
    fixed = rd_code;
    if (rd_single)
      fixed[rsyn] = ~rd_code[rsyn];
  end

endmodule // eic_ecc

/* rtl/eic_params.svh */
`ifndef EIC_PARAMS_SVH
`define EIC_PARAMS_SVH

// =====================================================================
// Widths and address bit positions
// =====================================================================
`define EIC_DATA_W       64
`define EIC_CODE_W       72
`define EIC_SYN_W        7
`define EIC_CNT_W        4
`define EIC_ROW_LSB      12
`define EIC_ROW_MSB      26
`define EIC_COL_LSB      5
`define EIC_COL_MSB      11
`define EIC_BLK_BIT_BASE 5'h17

// =====================================================================
// Processor bus beat timing, in bus clocks
// =====================================================================
`define EIC_RD_IDLE      4'h9
`define EIC_RD_AL_MISS   4'h7
`define EIC_RD_AL_HIT    4'h3
`define EIC_RD_MA_MISS   4'h6
`define EIC_RD_MA_HIT    4'h2
`define EIC_RD_AL_GAP2   4'h1
`define EIC_RD_AL_GAP3   4'h2
`define EIC_RD_AL_GAP4   4'h1
`define EIC_RD_MA_GAP2   4'h3
`define EIC_RD_MA_GAP3   4'h1
`define EIC_RD_MA_GAP4   4'h1
`define EIC_WR_IDLE      4'h4
`define EIC_WR_MISS      4'h7
`define EIC_WR_HIT       4'h3
`define EIC_WR_GAP       4'h1
`define EIC_SR_IDLE      4'h9
`define EIC_SR_MISS      4'h8
`define EIC_SR_HIT       4'h6
`define EIC_SW_IDLE      4'h4
`define EIC_SW_MISS      4'hc
`define EIC_SW_HIT       4'ha

// =====================================================================
// PCI side timing
// =====================================================================
`define EIC_ARB_CLKS     2'h2
`define EIC_PCI_DIV      2'h2
`define EIC_PCI_RD_FIRST 4'ha
`define EIC_PCI_WR_FIRST 4'h3
`define EIC_ARB_PCI      4'h1
`define EIC_POST_EXTRA   4'h2

`endif

/* rtl/eic_pkg.sv */
package eic_pkg;
`include "eic_params.svh"

  typedef enum logic [3:0]
  {
    EIC_IDLE = 4'h1,
    EIC_CPU  = 4'h2,
    EIC_ARB  = 4'h4,
    EIC_PCI  = 4'h8
  } eic_state_t;

  typedef enum logic [2:0]
  {
    EIC_K_NONE = 3'h0,
    EIC_K_BRD  = 3'h1,
    EIC_K_BWR  = 3'h2,
    EIC_K_SRD  = 3'h3,
    EIC_K_SWR  = 3'h4
  } eic_kind_t;

  typedef struct packed {
    eic_state_t                 st;
    eic_kind_t                  kind;
    eic_kind_t                  prev_kind;
    logic                       b2b;
    logic                       open_valid;
    logic [14:0]                open_row;
    logic                       open_blk;
    logic [`EIC_CNT_W-1:0]      cnt;
    logic [1:0]                 beat;
    logic                       mis;
    logic [31:0]                addr;
    logic                       last_way;
    logic [1:0]                 arb;
    logic [1:0]                 div;
    logic                       pci_en;
    logic                       pci_wr;
    logic                       pci_burst;
    logic                       address_ack_n_n;
    logic                       ta_n;
    logic [`EIC_DATA_W-1:0]     rd_data;
    logic [`EIC_DATA_W-1:0]     s0;
    logic [`EIC_DATA_W-1:0]     s1;
    logic [1:0]                 bcnt;
    logic [1:0]                 ras_n;
    logic [1:0]                 cas_n;
    logic [11:0]                dram_addr;
    logic                       we_n;
    logic [`EIC_CODE_W-1:0]     dq_out;
    logic                       dq_oe;
    logic                       fix;
    logic                       merr;
    logic                       pci_beat;
    logic [`EIC_DATA_W-1:0]     pci_rd_data;
  } eic_regs_t;

  localparam eic_regs_t EIC_RST = '{st: EIC_IDLE, kind: EIC_K_NONE,
    prev_kind: EIC_K_NONE, address_ack_n_n: 1'b1, ta_n: 1'b1, ras_n: 2'h3,
    cas_n: 2'h3, we_n: 1'b1, default: '0};

endpackage

/* tb/eic_dram_model.sv */
`timescale 1ns/1ps
// ==========================================================
// DRAM array model, keyed by column and way only
// ==========================================================
module eic_dram_model
(
  input  wire logic        core_clk,
  input  wire logic [1:0]  cas_n,
  input  wire logic [11:0] dram_addr,
  input  wire logic        dram_we_n,
  input  wire logic [71:0] dram_dq_out,
  input  wire logic        dram_dq_oe,
  input  wire logic [71:0] flip,
  output logic      [71:0] dram_dq_in
);
  logic [71:0] mem [0:1023];
  logic [71:0] last = '0;
  logic        way;
  logic        rd;

  assign way = cas_n[0];
  assign rd  = (cas_n != 2'h3) && dram_we_n;

  always @(posedge core_clk)
  begin
    if (!dram_we_n && dram_dq_oe && cas_n != 2'h3)
      mem[{way, dram_addr[8:0]}] <= dram_dq_out;
    if (rd)
      last <= dram_dq_in;
  end

  // Idle bus shows the inverse so a late sample cannot match
  always_comb
    if (rd)
      dram_dq_in = mem[{way, dram_addr[8:0]}] ^ flip;
    else
      dram_dq_in = ~last;
endmodule // eic_dram_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic core_clk = 0, reset_n = 0, transfer_start_n = 1, bus_write = 0;
  logic bus_burst = 0, bus_hold = 0, mem_two_blocks = 1, pci_req = 0;
  logic pci_write = 0, pci_burst = 0, pci_last = 1, pci_post_empty = 1;
  logic [31:0] bus_addr = '0, pci_addr = '0;
  logic [63:0] bus_wr_data = '0, pci_wr_data = '0, bus_rd_data, pci_rd_data;
  logic [1:0]  mem_size_sel = 2'h0, ras_n, cas_n;
  logic [11:0] dram_addr;
  logic [71:0] dq_in, dq_out, flip = '0;
  logic address_ack_n, transfer_ack_n, dram_we_n, dq_oe, fix, merr, pci_beat;
  logic chk_data = 1;
  int   error_cnt = 0, num_checks = 0;

  always #2 core_clk = ~core_clk;

  eic_ctrl dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .transfer_start_n(transfer_start_n), .bus_addr(bus_addr),
    .bus_write(bus_write), .bus_burst(bus_burst), .bus_wr_data(bus_wr_data),
    .bus_hold(bus_hold), .address_ack_n(address_ack_n),
    .transfer_ack_n(transfer_ack_n), .bus_rd_data(bus_rd_data),
    .mem_two_blocks(mem_two_blocks), .mem_size_sel(mem_size_sel),
    .ras_n(ras_n), .cas_n(cas_n), .dram_addr(dram_addr),
    .dram_we_n(dram_we_n), .dram_dq_in(dq_in), .dram_dq_out(dq_out),
    .dram_dq_oe(dq_oe), .ecc_single_fix(fix), .ecc_multi_err(merr),
    .pci_req(pci_req), .pci_write(pci_write), .pci_burst(pci_burst),
    .pci_last(pci_last), .pci_addr(pci_addr), .pci_wr_data(pci_wr_data),
    .pci_post_empty(pci_post_empty), .pci_beat(pci_beat),
    .pci_rd_data(pci_rd_data));

  eic_dram_model mem_u (.core_clk(core_clk), .cas_n(cas_n),
    .dram_addr(dram_addr), .dram_we_n(dram_we_n), .dram_dq_out(dq_out),
    .dram_dq_oe(dq_oe), .flip(flip), .dram_dq_in(dq_in));

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // ==========================================================
  // Processor transfer; returns in the cycle of its last ack
  // ==========================================================
  // Word w of a line always holds base + w, whatever the start beat
  task automatic xfer(input logic wr, input logic bst, input logic [31:0] a,
                      input logic [63:0] base, input int g0, g1, g2, g3);
    int n, k, last;
    int eg[4];
    logic [1:0] w;
    begin
      eg = '{g0, g1, g2, g3};
      n = 0;
      k = 0;
      last = 0;
      w = a[4:3];
      bus_write = wr;
      bus_burst = bst;
      bus_addr = a;
      bus_wr_data = base + {62'h0, w};
      transfer_start_n = 0;
      while (k < (bst ? 4 : 1) && n < 80)
      begin
        @(posedge core_clk);
        #1;
        n++;
        transfer_start_n = 1;
        if (n == 1)
        begin
          `CHK(address_ack_n, 1'b0)
          `CHK(ras_n, (mem_two_blocks && a[23 + mem_size_sel]) ? 2'h1 : 2'h2)
        end
        if (transfer_ack_n === 1'b0)
        begin
          if (g0 >= 0)
            `CHK(n - last, eg[k])
          if (!wr && chk_data)
            `CHK(bus_rd_data, base + {62'h0, 2'(w + 2'(k))})
          last = n;
          k++;
          bus_wr_data = base + {62'h0, 2'(w + 2'(k))};
        end
      end
      `CHK(k, bst ? 4 : 1)
    end
  endtask

  task automatic pci(input logic wr, input logic [31:0] a, input logic [63:0] d,
                     input int lo, input int hi);
    int n;
    begin
      n = 0;
      pci_write = wr;
      pci_addr = a;
      pci_wr_data = d;
      pci_req = 1;
      while (pci_beat !== 1'b1 && n < 60)
        begin
          @(posedge core_clk);
          #1;
          n++;
        end
      pci_req = 0;
      `CHK(n >= lo && n <= hi, 1'b1)
      if (!wr)
        `CHK(pci_rd_data, d)
      cyc(3);
    end
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_idle;
    xfer(1, 0, 32'h48, 64'h1000, 4, 0, 0, 0);
    cyc(2);
    xfer(0, 0, 32'h48, 64'h1000, 9, 0, 0, 0);
    cyc(2);
    xfer(1, 1, 32'h100, 64'h2000, 4, 1, 1, 1);
    cyc(2);
    xfer(0, 1, 32'h100, 64'h2000, 9, 1, 2, 1);
    cyc(2);
    xfer(0, 1, 32'h108, 64'h2000, 9, 3, 1, 1);
    cyc(2);
    mem_size_sel = 2'h1;
    xfer(1, 0, 32'h0100_0048, 64'h1000, 4, 0, 0, 0);
    mem_size_sel = 2'h0;
    $display("test idle latency done");
  endtask

  task automatic t_b2b;
    cyc(3);
    xfer(0, 1, 32'h100, 64'h2000, 9, 1, 2, 1);
    xfer(0, 1, 32'h100, 64'h2000, 3, 1, 2, 1);
    xfer(0, 1, 32'h108, 64'h2000, 2, 3, 1, 1);
    xfer(0, 1, 32'h1100, 64'h2000, 7, 1, 2, 1);
    xfer(0, 1, 32'h108, 64'h2000, 6, 3, 1, 1);
    cyc(3);
    xfer(0, 0, 32'h48, 64'h1000, 9, 0, 0, 0);
    xfer(0, 0, 32'h48, 64'h1000, 6, 0, 0, 0);
    xfer(0, 0, 32'h1048, 64'h1000, 8, 0, 0, 0);
    cyc(3);
    xfer(1, 0, 32'h48, 64'h1000, 4, 0, 0, 0);
    xfer(1, 0, 32'h1048, 64'h1000, 12, 0, 0, 0);
    xfer(1, 0, 32'h1048, 64'h1000, 10, 0, 0, 0);
    cyc(3);
    xfer(1, 1, 32'h100, 64'h2000, 4, 1, 1, 1);
    xfer(1, 1, 32'h100, 64'h2000, 3, 1, 1, 1);
    xfer(1, 1, 32'h1100, 64'h2000, 7, 1, 1, 1);
    $display("test back to back done");
  endtask

  task automatic t_ecc;
    cyc(3);
    flip = 72'h20;
    xfer(0, 0, 32'h48, 64'h1000, 9, 0, 0, 0);
    `CHK({fix, merr}, 2'h2)
    cyc(3);
    flip = 72'h60;
    chk_data = 0;
    xfer(0, 0, 32'h48, 64'h1000, 9, 0, 0, 0);
    `CHK({fix, merr}, 2'h1)
    flip = '0;
    chk_data = 1;
    $display("test ecc done");
  endtask

  // Receiver stalls the whole burst; the buffer must lose nothing
  task automatic t_hold;
    cyc(3);
    bus_hold = 1;
    fork
      xfer(0, 1, 32'h118, 64'h2000, -1, 0, 0, 0);
      begin
        cyc(20);
        bus_hold = 0;
      end
    join
    $display("test receiver stall done");
  endtask

  task automatic t_pci;
    cyc(3);
    pci(1, 32'h140, 64'hfeed_0001_cafe_0002, 5, 8);
    pci(0, 32'h140, 64'hfeed_0001_cafe_0002, 19, 22);
    $display("test pci done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    cyc(4);
    reset_n = 1;
    t_idle();
    t_b2b();
    t_ecc();
    t_hold();
    t_pci();
    wrap_up();
  end

  initial
  begin
    #20000;
    error_cnt++;
    wrap_up();
  end
endmodule // tb_top
